// ==== hdl/cal_cfg.svh ====
// Constants for the arithmetic, logic and call execution slice.
// Assumes inclusion by bare name from the package and the design files.
`ifndef CAL_CFG_SVH
`define CAL_CFG_SVH
`define CAL_TS_SHORT 2'h1
`define CAL_TS_CALL 2'h2
`define CAL_FLAG_RST 4'h0
`define CAL_PC_RST 16'h0000
`define CAL_ACC_A_IDX 5'h00
`define CAL_ACC_B_IDX 5'h04
`define CAL_IDX_LO_BASE 5'h0c
`define CAL_BANK_A_TOP 5'h04
`define CAL_BANK_B_TOP 5'h0c
`define CAL_NUM_REGS 64
`define CAL_STK_DEPTH 4
`endif

// ==== hdl/cal_pkg.sv ====
// Types shared by the execution slice.
// Assumes cal_cfg.svh is on the include path.
`include "cal_cfg.svh"
package cal_pkg;
	typedef enum logic [3:0] {
		CAL_OP_NONE = 4'h0,
		CAL_OP_ADD_CARRY_ACC = 4'h1,
		CAL_OP_ADD_ACC = 4'h2,
		CAL_OP_AND_ACC = 4'h3,
		CAL_OP_ADDI = 4'h4,
		CAL_OP_ANDI = 4'h5,
		CAL_OP_BIT = 4'h6,
		CAL_OP_CMPI = 4'h7,
		CAL_OP_CALL = 4'h8
	} cal_op_e;
	typedef enum logic [1:0] {
		CAL_MIR_DEC = 2'h0,
		CAL_MIR_SAME = 2'h1,
		CAL_MIR_INC = 2'h2,
		CAL_MIR_PREINC = 2'h3
	} cal_mir_e;
	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} cal_flags_s;
	typedef struct packed {
		cal_op_e op;
		logic [4:0] src;
		logic [4:0] dst;
		logic dst_mem;
		logic [1:0] ir_sel;
		cal_mir_e mir;
		logic [7:0] imm;
	} cal_instr_s;
	typedef struct packed {
		logic [15:0] pc;
		logic global_irq_enable;
		cal_flags_s flags;
		logic bank_a;
		logic bank_b;
	} cal_stack_s;
endpackage : cal_pkg

// ==== hdl/cal_alu.sv ====
// Combinational ALU for the add, add-carry, AND and subtract-compare forms.
// Assumes operands are already selected by the execution unit.
`timescale 1ns/100ps
module cal_alu (
	// Operands
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic carry_i,
	input wire logic sub_i,
	input wire logic logic_i,
	// Result
	output logic [7:0] res_o,
	output cal_pkg::cal_flags_s flags_o
);
	logic [8:0] sum;
	logic [7:0] b_eff;
	always_comb begin
		b_eff = sub_i ? ~b_i : b_i;
		sum = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, (sub_i | carry_i)};
		res_o = logic_i ? (a_i & b_i) : sum[7:0];
		flags_o.n = res_o[7];
		flags_o.z = (res_o == 8'h00);
		// Borrow shows as carry set after a subtract, so carry set means less than.
		flags_o.c = sub_i ? ~sum[8] : sum[8];
		flags_o.v = (a_i[7] == b_eff[7]) && (sum[7] != a_i[7]);
	end
endmodule // cal_alu

// ==== hdl/cal_exec.sv ====
// Execution slice: accumulator-form and immediate arithmetic, bit test,
// compare and relative call. Assumes one instruction is offered at a time
// with instr_valid_i, and that data memory accepts a write in one cycle.
//
// Behaviour
// - Add-carry-with-acc sums source, active accumulator and carry; writes result; sets NZCV.
// - Accumulator forms write a register or indexed data memory.
// - Bank selection picks which accumulator is active.
// - Add immediate adds 8-bit value to limited register, writes back, NZCV.
// - Limited register field reaches only R0-R15.
// - Immediate may be read unsigned 0-255 or signed -128..127.
// - Add-with-acc sums source and accumulator without carry; NZCV.
// - AND immediate masks limited register, writes back, sets N and Z only.
// - And-with-acc masks source with accumulator, writes destination, N and Z only.
// - Bit test ANDs limited register with immediate; flags only, no write.
// - Compare subtracts immediate from limited register; NZCV, result dropped.
// - After compare, C means less, Z equal, neither means greater.
// - Call pushes PC, flags, interrupt enable and bank selections together.
// - Call loads PC plus sign-extended 8-bit displacement.
// - Call reach is +127 to -128 words.
// - Displacement counts from the address after the call.
// - Post-increment index is bumped by one after the memory write.
// - Index modes: post-decrement, unchanged, post-increment, pre-increment.
`timescale 1ns/100ps
`include "cal_cfg.svh"
module cal_exec #(
	parameter int STK_DEPTH = `CAL_STK_DEPTH
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Instruction offered by the fetch unit
	input wire logic instr_valid_i,
	input wire cal_pkg::cal_instr_s instr_i,
	input wire logic [15:0] next_pc_i,
	output logic instr_ready_o,
	// Bank selections and interrupt enable
	input wire logic bank_a_i,
	input wire logic bank_b_i,
	input wire logic global_irq_enable_i,
	// Indexed data memory write
	output logic mem_we_o,
	output logic [15:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	// Processor state
	output cal_pkg::cal_flags_s flags_o,
	output logic [15:0] pc_o,
	output logic pc_load_o,
	output cal_pkg::cal_stack_s stack_top_o,
	output logic [$clog2(STK_DEPTH+1)-1:0] stack_count_o,
	// Register file observation
	input wire logic [4:0] reg_rd_sel_i,
	output logic [7:0] reg_rd_data_o
);
	localparam int SW = $clog2(STK_DEPTH+1);

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_LAST = 2'h2
	} cal_state_e;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Registers R0-R3 and R4-R11 exist twice; the bank bits pick the copy.
	function automatic logic [5:0] phys_idx(input logic [4:0] r, input logic ba, input logic bb);
		if (r < `CAL_BANK_A_TOP)
			phys_idx = {ba, r};
		else if (r < `CAL_BANK_B_TOP)
			phys_idx = {bb, r};
		else
			phys_idx = {1'b0, r};
	endfunction

	function automatic logic [15:0] sext8(input logic [7:0] d);
		sext8 = {{8{d[7]}}, d};
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] regs_reg [`CAL_NUM_REGS];
	logic [7:0] regs_next [`CAL_NUM_REGS];
	cal_state_e state_reg, state_next;
	logic [1:0] tcnt_reg, tcnt_next;
	cal_pkg::cal_instr_s ins_reg, ins_next;
	cal_pkg::cal_flags_s flags_reg, flags_next;
	logic [15:0] pc_reg, pc_next;
	logic pc_load_reg, pc_load_next;
	cal_pkg::cal_stack_s stk_reg [STK_DEPTH];
	cal_pkg::cal_stack_s stk_next [STK_DEPTH];
	logic [SW-1:0] sp_reg, sp_next;
	logic mem_we_reg, mem_we_next;
	logic [15:0] mem_addr_reg, mem_addr_next;
	logic [7:0] mem_wdata_reg, mem_wdata_next;
	logic [15:0] npc_reg, npc_next;

	// ----------------------------------------------------------------
	// Operand selection and ALU
	// ----------------------------------------------------------------
	logic [7:0] opa, opb, alu_res;
	logic alu_carry, alu_sub, alu_logic;
	cal_pkg::cal_flags_s alu_flags;
	logic [4:0] acc_idx;
	logic [4:0] lim_src;
	logic [5:0] ir_lo;
	logic [15:0] ir_val;
	logic [7:0] lim_val;

	always_comb begin
		// Bank B's copy of register 4 serves as the accumulator when selected.
		acc_idx = bank_b_i ? `CAL_ACC_B_IDX : `CAL_ACC_A_IDX;
		lim_src = {1'b0, ins_reg.src[3:0]};
		ir_lo = phys_idx(`CAL_IDX_LO_BASE + {2'h0, ins_reg.ir_sel, 1'b0}, bank_a_i, bank_b_i);
		ir_val = {regs_reg[ir_lo + 6'h01], regs_reg[ir_lo]};
		lim_val = regs_reg[phys_idx(lim_src, bank_a_i, bank_b_i)];
		opa = 8'h00;
		opb = 8'h00;
		alu_carry = 1'b0;
		alu_sub = 1'b0;
		alu_logic = 1'b0;
		unique case (ins_reg.op)
			cal_pkg::CAL_OP_ADD_CARRY_ACC: begin
				opa = regs_reg[phys_idx(ins_reg.src, bank_a_i, bank_b_i)];
				opb = regs_reg[phys_idx(acc_idx, bank_a_i, bank_b_i)];
				alu_carry = flags_reg.c;
			end
			cal_pkg::CAL_OP_ADD_ACC: begin
				opa = regs_reg[phys_idx(ins_reg.src, bank_a_i, bank_b_i)];
				opb = regs_reg[phys_idx(acc_idx, bank_a_i, bank_b_i)];
			end
			cal_pkg::CAL_OP_AND_ACC: begin
				opa = regs_reg[phys_idx(ins_reg.src, bank_a_i, bank_b_i)];
				opb = regs_reg[phys_idx(acc_idx, bank_a_i, bank_b_i)];
				alu_logic = 1'b1;
			end
			cal_pkg::CAL_OP_ADDI: begin
				opa = regs_reg[phys_idx(lim_src, bank_a_i, bank_b_i)];
				opb = ins_reg.imm;
			end
			cal_pkg::CAL_OP_ANDI, cal_pkg::CAL_OP_BIT: begin
				opa = regs_reg[phys_idx(lim_src, bank_a_i, bank_b_i)];
				opb = ins_reg.imm;
				alu_logic = 1'b1;
			end
			cal_pkg::CAL_OP_CMPI: begin
				opa = regs_reg[phys_idx(lim_src, bank_a_i, bank_b_i)];
				opb = ins_reg.imm;
				alu_sub = 1'b1;
			end
			default: begin
			end
		endcase
	end

	cal_alu u_alu (
		.a_i(opa),
		.b_i(opb),
		.carry_i(alu_carry),
		.sub_i(alu_sub),
		.logic_i(alu_logic),
		.res_o(alu_res),
		.flags_o(alu_flags)
	);

	// ----------------------------------------------------------------
	// Sequencer and result write-back
	// ----------------------------------------------------------------
	logic [5:0] dst_idx;
	logic [15:0] ir_upd;
	logic [15:0] eff_addr;

	always_comb begin
		state_next = state_reg;
		tcnt_next = tcnt_reg;
		ins_next = ins_reg;
		flags_next = flags_reg;
		pc_next = pc_reg;
		pc_load_next = 1'b0;
		sp_next = sp_reg;
		mem_we_next = 1'b0;
		mem_addr_next = mem_addr_reg;
		mem_wdata_next = mem_wdata_reg;
		npc_next = npc_reg;
		regs_next = regs_reg;
		stk_next = stk_reg;
		dst_idx = 6'h00;
		ir_upd = ir_val;
		eff_addr = ir_val;
		unique case (state_reg)
			ST_IDLE: begin
				if (instr_valid_i) begin
					ins_next = instr_i;
					npc_next = next_pc_i;
					tcnt_next = (instr_i.op == cal_pkg::CAL_OP_CALL) ? `CAL_TS_CALL : `CAL_TS_SHORT;
					state_next = ST_EXEC;
				end
			end
			ST_EXEC: begin
				tcnt_next = tcnt_reg - 2'h1;
				if (tcnt_reg == 2'h1)
					state_next = ST_LAST;
			end
			ST_LAST: begin
				state_next = ST_IDLE;
				unique case (ins_reg.op)
					cal_pkg::CAL_OP_ADD_CARRY_ACC, cal_pkg::CAL_OP_ADD_ACC, cal_pkg::CAL_OP_AND_ACC: begin
						if (ins_reg.op == cal_pkg::CAL_OP_AND_ACC)
							flags_next = '{n: alu_flags.n, z: alu_flags.z, c: flags_reg.c, v: flags_reg.v};
						else
							flags_next = alu_flags;
						if (ins_reg.dst_mem) begin
							unique case (ins_reg.mir)
								cal_pkg::CAL_MIR_DEC: ir_upd = ir_val - 16'h0001;
								cal_pkg::CAL_MIR_SAME: ir_upd = ir_val;
								cal_pkg::CAL_MIR_INC: ir_upd = ir_val + 16'h0001;
								cal_pkg::CAL_MIR_PREINC: begin
									ir_upd = ir_val + 16'h0001;
									eff_addr = ir_upd;
								end
							endcase
							mem_we_next = 1'b1;
							mem_addr_next = eff_addr;
							mem_wdata_next = alu_res;
							regs_next[ir_lo] = ir_upd[7:0];
							regs_next[ir_lo + 6'h01] = ir_upd[15:8];
						end else begin
							dst_idx = phys_idx(ins_reg.dst, bank_a_i, bank_b_i);
							regs_next[dst_idx] = alu_res;
						end
					end
					cal_pkg::CAL_OP_ADDI: begin
						regs_next[phys_idx(lim_src, bank_a_i, bank_b_i)] = alu_res;
						flags_next = alu_flags;
					end
					cal_pkg::CAL_OP_ANDI: begin
						regs_next[phys_idx(lim_src, bank_a_i, bank_b_i)] = alu_res;
						flags_next = '{n: alu_flags.n, z: alu_flags.z, c: flags_reg.c, v: flags_reg.v};
					end
					cal_pkg::CAL_OP_BIT: begin
						flags_next = '{n: alu_flags.n, z: alu_flags.z, c: flags_reg.c, v: flags_reg.v};
					end
					cal_pkg::CAL_OP_CMPI: begin
						flags_next = alu_flags;
					end
					cal_pkg::CAL_OP_CALL: begin
						if (sp_reg < SW'(STK_DEPTH)) begin
							stk_next[sp_reg[$clog2(STK_DEPTH)-1:0]] = '{pc: npc_reg, global_irq_enable: global_irq_enable_i,
								flags: flags_reg, bank_a: bank_a_i, bank_b: bank_b_i};
							sp_next = sp_reg + SW'(1);
						end
						pc_next = npc_reg + sext8(ins_reg.imm);
						pc_load_next = 1'b1;
					end
					default: begin
					end
				endcase
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state_reg <= ST_IDLE;
			tcnt_reg <= 2'h0;
			ins_reg <= '0;
			flags_reg <= `CAL_FLAG_RST;
			pc_reg <= `CAL_PC_RST;
			pc_load_reg <= 1'b0;
			sp_reg <= '0;
			mem_we_reg <= 1'b0;
			mem_addr_reg <= 16'h0000;
			mem_wdata_reg <= 8'h00;
			npc_reg <= 16'h0000;
			for (int i = 0; i < `CAL_NUM_REGS; i++)
				regs_reg[i] <= 8'h00;
			for (int i = 0; i < STK_DEPTH; i++)
				stk_reg[i] <= '0;
		end else begin
			state_reg <= state_next;
			tcnt_reg <= tcnt_next;
			ins_reg <= ins_next;
			flags_reg <= flags_next;
			pc_reg <= pc_next;
			pc_load_reg <= pc_load_next;
			sp_reg <= sp_next;
			mem_we_reg <= mem_we_next;
			mem_addr_reg <= mem_addr_next;
			mem_wdata_reg <= mem_wdata_next;
			npc_reg <= npc_next;
			regs_reg <= regs_next;
			stk_reg <= stk_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign instr_ready_o = (state_reg == ST_IDLE);
	assign mem_we_o = mem_we_reg;
	assign mem_addr_o = mem_addr_reg;
	assign mem_wdata_o = mem_wdata_reg;
	assign flags_o = flags_reg;
	assign pc_o = pc_reg;
	assign pc_load_o = pc_load_reg;
	assign stack_count_o = sp_reg;
	assign stack_top_o = (sp_reg == '0) ? '0 : stk_reg[sp_reg[$clog2(STK_DEPTH)-1:0] - 1'b1];
	assign reg_rd_data_o = regs_reg[phys_idx(reg_rd_sel_i, bank_a_i, bank_b_i)];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	short_latency_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(instr_valid_i && instr_ready_o && instr_i.op != cal_pkg::CAL_OP_CALL) |=> !instr_ready_o [*2] ##1 instr_ready_o)
		else $error("short op did not take two T-states");
	call_latency_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(instr_valid_i && instr_ready_o && instr_i.op == cal_pkg::CAL_OP_CALL) |-> ##4 pc_load_o)
		else $error("call did not load pc on time");
	call_target_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		pc_load_o |-> pc_o == $past(npc_reg) + sext8($past(ins_reg.imm)))
		else $error("call target wrong");
	call_push_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(pc_load_o && stack_count_o != $past(stack_count_o)) |-> stack_top_o.pc == $past(npc_reg))
		else $error("call push lost pc");
	bit_nowrite_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(state_reg == ST_LAST && ins_reg.op inside {cal_pkg::CAL_OP_BIT, cal_pkg::CAL_OP_CMPI})
		|=> lim_val == $past(lim_val) && !mem_we_o)
		else $error("test or compare changed state");
	and_flags_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(state_reg == ST_LAST && ins_reg.op inside {cal_pkg::CAL_OP_AND_ACC, cal_pkg::CAL_OP_ANDI})
		|=> flags_o.c == $past(flags_o.c) && flags_o.v == $past(flags_o.v))
		else $error("AND touched carry or overflow");
	cmp_flags_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(state_reg == ST_LAST && ins_reg.op == cal_pkg::CAL_OP_CMPI) |=> flags_o.c == ($past(opa) < $past(opb)))
		else $error("compare carry not less-than");
	postinc_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(state_reg == ST_LAST && ins_reg.dst_mem && ins_reg.mir == cal_pkg::CAL_MIR_INC && ins_reg.op
		inside {cal_pkg::CAL_OP_ADD_ACC, cal_pkg::CAL_OP_ADD_CARRY_ACC, cal_pkg::CAL_OP_AND_ACC})
		|=> mem_we_o && mem_addr_o == $past(ir_val) && ir_val == $past(ir_val) + 16'h0001)
		else $error("post-increment address wrong");
endmodule // cal_exec

// ==== verification/cal_dmem.sv ====
// Data memory model on the far side of the execution slice's indexed write port.
// Assumes writes arrive as one-cycle strobes on the system clock.
`timescale 1ns/100ps
module cal_dmem (
	// Clock
	input wire logic clk_sys_i,
	// Write side
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	// Look-up side
	input wire logic [15:0] rd_addr_i,
	output logic [7:0] rd_data_o
);
	// ----
	// Storage
	// ----
	logic [7:0] mem_reg [0:65535];

	// Locations never written read back unknown, so a missed write cannot pass.
	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem_reg[addr_i] <= wdata_i;
		end
	end

	assign rd_data_o = mem_reg[rd_addr_i];
endmodule // cal_dmem

// ==== verification/cpu_arith_logic_call_ops_tb.sv ====
// Self-checking bench for the execution slice: a table of plain cases, then banks, index modes, calls and reset.
// Assumes the design files and the data memory model are compiled before it.
`timescale 1ns/100ps
module cpu_arith_logic_call_ops_tb;
	typedef struct packed {
		logic [3:0] op;
		logic [4:0] s;
		logic [4:0] d;
		logic [7:0] imm;
		logic [7:0] res;
		logic [3:0] fl;
	} cal_row_s;

	// ----
	// Signals
	// ----
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic instr_valid_i = 1'b0;
	cal_pkg::cal_instr_s instr_i = '0;
	logic [15:0] next_pc_i = 16'h0000;
	logic bank_a_i = 1'b0;
	logic bank_b_i = 1'b0;
	logic global_irq_enable_i = 1'b0;
	logic [1:0] isel = 2'h0;
	logic [4:0] reg_rd_sel_i = 5'h00;
	logic instr_ready_o;
	logic mem_we_o;
	logic pc_load_o;
	logic [15:0] mem_addr_o;
	logic [15:0] pc_o;
	logic [7:0] mem_wdata_o;
	logic [7:0] reg_rd_data_o;
	logic [7:0] dmem_q;
	cal_pkg::cal_flags_s flags_o;
	cal_pkg::cal_stack_s stack_top_o;
	logic [2:0] stack_count_o;
	logic [15:0] wa;
	logic [7:0] wd;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	int lat;
	int pcl;
	logic [1:0] md [0:3] = '{2'h2, 2'h3, 2'h0, 2'h1};
	logic [7:0] ea [0:3] = '{8'h40, 8'h42, 8'h42, 8'h41};
	logic [7:0] er [0:3] = '{8'h41, 8'h42, 8'h41, 8'h41};
	cal_row_s rows [0:15] = '{
		'{4'h4, 5'h01, 5'h01, 8'h7f, 8'h7f, 4'h0},
		'{4'h4, 5'h01, 5'h01, 8'h01, 8'h80, 4'h9},
		'{4'h4, 5'h01, 5'h01, 8'hff, 8'h7f, 4'h3},
		'{4'h4, 5'h00, 5'h00, 8'h05, 8'h05, 4'h0},
		'{4'h2, 5'h01, 5'h02, 8'h00, 8'h84, 4'h9},
		'{4'h4, 5'h0f, 5'h0f, 8'h81, 8'h81, 4'h8},
		'{4'h4, 5'h0f, 5'h0f, 8'h80, 8'h01, 4'h3},
		'{4'h1, 5'h0f, 5'h06, 8'h00, 8'h07, 4'h0},
		'{4'h4, 5'h06, 5'h06, 8'hff, 8'h06, 4'h2},
		'{4'h5, 5'h02, 5'h02, 8'hf0, 8'h80, 4'ha},
		'{4'h3, 5'h06, 5'h07, 8'h00, 8'h04, 4'h2},
		'{4'h6, 5'h07, 5'h07, 8'h03, 8'h04, 4'h6},
		'{4'h7, 5'h07, 5'h07, 8'h04, 8'h04, 4'h4},
		'{4'h7, 5'h07, 5'h07, 8'h05, 8'h04, 4'ha},
		'{4'h7, 5'h07, 5'h07, 8'h03, 8'h04, 4'h0},
		'{4'h7, 5'h01, 5'h01, 8'h80, 8'h7f, 4'hb}
	};

	// ----
	// Design and far side
	// ----
	cal_exec #(.STK_DEPTH(4)) u_cal_exec (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.instr_valid_i(instr_valid_i),
		.instr_i(instr_i),
		.next_pc_i(next_pc_i),
		.instr_ready_o(instr_ready_o),
		.bank_a_i(bank_a_i),
		.bank_b_i(bank_b_i),
		.global_irq_enable_i(global_irq_enable_i),
		.mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o),
		.flags_o(flags_o),
		.pc_o(pc_o),
		.pc_load_o(pc_load_o),
		.stack_top_o(stack_top_o),
		.stack_count_o(stack_count_o),
		.reg_rd_sel_i(reg_rd_sel_i),
		.reg_rd_data_o(reg_rd_data_o)
	);

	cal_dmem u_cal_dmem (
		.clk_sys_i(clk_sys_i),
		.we_i(mem_we_o),
		.addr_i(mem_addr_o),
		.wdata_i(mem_wdata_o),
		.rd_addr_i(16'h0040),
		.rd_data_o(dmem_q)
	);

	initial begin
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	// ----
	// Tasks
	// ----
	task automatic final_report;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_flags(input logic [3:0] e);
		chk_val("flags", e, flags_o);
	endtask

	// Offers one instruction, then watches every cycle until ready returns.
	task automatic issue(input logic [3:0] op, input logic [4:0] s, input logic [4:0] d, input logic m,
		input logic [1:0] mir, input logic [7:0] imm);
		instr_i = '{cal_pkg::cal_op_e'(op), s, d, m, isel, cal_pkg::cal_mir_e'(mir), imm};
		reg_rd_sel_i = d;
		instr_valid_i = 1'b1;
		wa = 16'hffff;
		@(posedge clk_sys_i);
		#2;
		instr_valid_i = 1'b0;
		lat = 0;
		pcl = 0;
		do begin
			@(posedge clk_sys_i);
			#2;
			lat++;
			if (pc_load_o === 1'b1) pcl = lat;
			if (mem_we_o === 1'b1) begin
				wa = mem_addr_o;
				wd = mem_wdata_o;
			end
		end while (instr_ready_o !== 1'b1 && lat < 8);
		chk_val("latency", (op == 4'h8) ? 3 : 2, lat);
	endtask

	task automatic peek(input logic [4:0] r, input logic [7:0] e);
		reg_rd_sel_i = r;
		@(posedge clk_sys_i);
		#2;
		chk_val("register", e, reg_rd_data_o);
	endtask

	task automatic pulse_reset(input int n);
		sys_rst_i = 1'b1;
		repeat (n) @(posedge clk_sys_i);
		#2;
		sys_rst_i = 1'b0;
		@(posedge clk_sys_i);
		#2;
		chk_val("stack depth", 0, stack_count_o);
		chk_flags(4'h0);
		chk_val("target", 16'h0000, pc_o);
		chk_val("ready", 1'b1, instr_ready_o);
	endtask

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			final_report();
		end
	end

	// ----
	// Sequence
	// ----
	initial begin
		pulse_reset(12);
		foreach (rows[i]) begin
			issue(rows[i].op, rows[i].s, rows[i].d, 1'b0, 2'h1, rows[i].imm);
			chk_val("result", rows[i].res, reg_rd_data_o);
			chk_flags(rows[i].fl);
		end
		// The alternate B copy supplies its own accumulator.
		bank_b_i = 1'b1;
		issue(4'h4, 5'h04, 5'h04, 1'b0, 2'h1, 8'h10);
		issue(4'h2, 5'h01, 5'h08, 1'b0, 2'h1, 8'h00);
		chk_val("result", 8'h8f, reg_rd_data_o);
		bank_b_i = 1'b0;
		peek(5'h04, 8'h00);
		peek(5'h00, 8'h05);
		issue(4'h4, 5'h0c, 5'h0c, 1'b0, 2'h1, 8'h40);
		for (int k = 0; k < 4; k++) begin
			issue(4'h2, 5'h06, 5'h00, 1'b1, md[k], 8'h00);
			chk_val("write address", {8'h00, ea[k]}, wa);
			chk_val("write data", 8'h0b, wd);
			peek(5'h0c, er[k]);
		end
		// The last index pair, R18 and R19, points the write at a second address.
		issue(4'h2, 5'h06, 5'h12, 1'b0, 2'h1, 8'h00);
		chk_val("result", 8'h0b, reg_rd_data_o);
		isel = 2'h3;
		issue(4'h2, 5'h06, 5'h00, 1'b1, 2'h2, 8'h00);
		isel = 2'h0;
		chk_val("write address", 16'h000b, wa);
		chk_val("write data", 8'h0b, wd);
		peek(5'h12, 8'h0c);
		chk_val("memory", 8'h0b, dmem_q);
		bank_a_i = 1'b1;
		global_irq_enable_i = 1'b1;
		issue(4'h7, 5'h01, 5'h01, 1'b0, 2'h1, 8'h80);
		chk_flags(4'hb);
		// Five calls into a four-deep stack: the last push must be dropped.
		for (int k = 0; k < 5; k++) begin
			next_pc_i = 16'h0100 + 16'(k);
			issue(4'h8, 5'h00, 5'h00, 1'b0, 2'h1, (k == 0) ? 8'h80 : 8'h7f);
			chk_val("call target", (k == 0) ? 16'h0080 : 16'h017f + 16'(k), pc_o);
			chk_val("load cycle", 3, pcl);
			chk_val("stack depth", (k < 4) ? k + 1 : 4, stack_count_o);
			chk_val("stack entry", {16'h0100 + 16'((k < 4) ? k : 3), 1'b1, 4'hb, 2'h2}, stack_top_o);
		end
		pulse_reset(1);
		peek(5'h0f, 8'h00);
		final_report();
	end
endmodule // cpu_arith_logic_call_ops_tb
